/* src/rsp_init_reset.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rsp_map.svh"

// Overview of operation
// - pin high resets, low lets cpu run
// - pin held in latch, cleared by 2 Hz
// - release may lag pin by 250 ms
// - pin pulses under 100 ns are ignored
// - key option off or ports 0-1/0-2/0-3
// - all selected keys high triggers reset
// - key condition filtered, held 1.5 ms
// - key condition qualified for 1 s
// - reset sets regulator and lcd to normal
// - halver only without high-speed clock
// - separate halver bits for core, lcd
// - high-speed regulator off until software enables
// - software selects core voltage source
// - lcd supply on/off and 16 levels
module rsp_init_reset #(
   parameter rsp_pkg::rsp_key_opt_t KEY_OPT   = rsp_pkg::RSP_KEY_0123,
   parameter bit                    QUALIFY   = 1'b1,
   parameter int                    OSC_DIV   = `RSP_OSC_DIV,
   parameter int                    FILT_EDGE = `RSP_KEY_FILT_EDGES,
   parameter int                    HOLD_EDGE = `RSP_KEY_HOLD_EDGES
) (
   // clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst_b,
   // pins from outside
   input  wire logic                      resetPin,
   input  wire logic                      lowSpeedOsc,
   input  wire logic [3:0]                keyIn,
   // clock controller, same domain
   input  wire logic                      hsClkActive,
   // register port
   input  wire logic [`RSP_ADDR_W-1:0]    addr,
   input  wire logic [`RSP_DATA_W-1:0]    wdata,
   input  wire logic                      wrStb,
   input  wire logic                      rdStb,
   output logic      [`RSP_DATA_W-1:0]    rdata,
   // reset and supply outputs
   output logic                           initReset,
   output logic                           cpuRun,
   output rsp_pkg::rsp_supply_t           supply
);

   localparam int              DIV_W    = $clog2(OSC_DIV);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
   localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(OSC_DIV / 2);
   localparam int              NSMP     = `RSP_RST_NOISE_SMP;
   localparam logic [1:0]      NSMP_TOP = 2'(NSMP - 1);

   // synchronised pins
   logic [5:0] pinSync;          // {keys, osc, reset}
   wire        rstPinS  = pinSync[0];
   wire        oscS     = pinSync[1];
   wire [3:0]  keyS     = pinSync[5:2];

   // oscillator edge and divider
   logic             oscPrev_ff;  // last synchronised osc level
   logic [DIV_W-1:0] divCnt_ff;   // osc edges within one 2 Hz period
   logic [DIV_W-1:0] nxt_divCnt;

   // reset pin noise filter and latch
   logic [1:0] highCnt_ff;       // consecutive high samples, saturating
   logic [1:0] nxt_highCnt;
   logic       latch_ff;         // internal initial reset latch
   logic       nxt_latch;

   // key path
   logic keyFiltered;            // combination past noise filter
   logic keyReset;               // combination qualified

   // software controls
   rsp_pkg::rsp_supply_t supply_ff;
   rsp_pkg::rsp_supply_t nxt_supply;
   logic [`RSP_DATA_W-1:0] rdata_ff;
   logic [`RSP_DATA_W-1:0] nxt_rdata;

   // all pins pass the double flop before any logic reads them
   rsp_sync #(
      .W (6)
   ) u_pin_sync (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .d       ({keyIn, lowSpeedOsc, resetPin}),
      .q       (pinSync)
   );

   // oscillator rising edge, once per osc period
   wire oscEdge = oscS & ~oscPrev_ff;

   // key combination filter and hold qualifier
   rsp_key_qual #(
      .KEY_OPT   (KEY_OPT),
      .QUALIFY   (QUALIFY),
      .FILT_EDGE (FILT_EDGE),
      .HOLD_EDGE (HOLD_EDGE)
   ) u_key_qual (
      .ref_clk     (ref_clk),
      .rst_b       (rst_b),
      .keySync     (keyS),
      .oscEdge     (oscEdge),
      .keyFiltered (keyFiltered),
      .keyReset    (keyReset)
   );

   // 2 Hz tick: high in the second half of each divider period
   wire tickHi  = (divCnt_ff >= DIV_HALF);

   // divider wraps after one 2 Hz period
   assign nxt_divCnt = !oscEdge ? divCnt_ff :
                       (divCnt_ff == DIV_LAST) ? '0 : divCnt_ff + DIV_W'(1);

   // a pin pulse seen on a single sample never counts as reset
   wire pinValid     = rstPinS && (highCnt_ff == NSMP_TOP);
   assign nxt_highCnt = !rstPinS ? 2'b00 :
                        (highCnt_ff == NSMP_TOP) ? highCnt_ff : highCnt_ff + 2'b01;

   // set wins over the tick clear; key source ored into the set
   assign nxt_latch = (pinValid || keyReset) ? 1'b1 :
                      (tickHi && !rstPinS)   ? 1'b0 :
                      latch_ff;

   // oscillator, divider, pin filter and latch
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         oscPrev_ff <= 1'b0;
         divCnt_ff  <= '0;
         highCnt_ff <= 2'b00;
         latch_ff   <= 1'b1;
      end else begin
         oscPrev_ff <= oscS;
         divCnt_ff  <= nxt_divCnt;
         highCnt_ff <= nxt_highCnt;
         latch_ff   <= nxt_latch;
      end
   end

   // register decode
   wire selSupply = (addr == `RSP_OFS_SUPPLY);
   wire selLevel  = (addr == `RSP_OFS_LCD_LEVEL);
   wire selStatus = (addr == `RSP_OFS_STATUS);
   wire wrSupply  = wrStb && selSupply;
   wire wrLevel   = wrStb && selLevel;

   // status word shows the block's own state
   wire [`RSP_DATA_W-1:0] statusWord = {3'b000, tickHi, hsClkActive, keyFiltered,
                                        keyReset, latch_ff};
   wire [`RSP_DATA_W-1:0] supplyWord = {3'b000, supply_ff.lcdSupplyOn, supply_ff.lcdHalver,
                                        supply_ff.coreHalver, supply_ff.coreFromHighSpeed,
                                        supply_ff.hsRegEnable};

   // read data stands only in the cycle after the strobe; unmapped reads zero
   assign nxt_rdata = !rdStb    ? '0 :
                      selSupply ? supplyWord :
                      selLevel  ? {4'h0, supply_ff.lcdBaseLevel} :
                      selStatus ? statusWord : '0;

   // supply control next value
   always_comb begin
      nxt_supply = supply_ff;
      if (wrSupply) begin
         // software owns regulator enable and core source
         nxt_supply.hsRegEnable       = wdata[`RSP_BIT_HS_REG_EN];
         nxt_supply.coreFromHighSpeed = wdata[`RSP_BIT_CORE_FROM_HS];
         nxt_supply.coreHalver        = wdata[`RSP_BIT_CORE_HALVER];
         nxt_supply.lcdHalver         = wdata[`RSP_BIT_LCD_HALVER];
         nxt_supply.lcdSupplyOn       = wdata[`RSP_BIT_LCD_ON];
      end
      if (wrLevel) begin
         nxt_supply.lcdBaseLevel = wdata[3:0];
      end
      // halving a regulator that feeds the fast clock would starve it
      if (hsClkActive) begin
         nxt_supply.coreHalver = 1'b0;
         nxt_supply.lcdHalver  = 1'b0;
      end
      // internal reset returns every supply to full normal mode
      if (latch_ff) begin
         nxt_supply = rsp_pkg::rsp_supply_t'({`RSP_RST_SUPPLY, 1'b0});
         nxt_supply.lcdBaseLevel = `RSP_RST_LCD_LEVEL;
      end
   end

   // register file and read data
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         supply_ff <= '0;
         rdata_ff  <= '0;
      end else begin
         supply_ff <= nxt_supply;
         rdata_ff  <= nxt_rdata;
      end
   end

   // outputs: the cpu runs only with the latch released
   assign initReset = latch_ff;
   assign cpuRun    = ~latch_ff;
   assign supply    = supply_ff;
   assign rdata     = rdata_ff;

   // checks on the reset path and supply controls
   sequence shortPulse;
      !rstPinS ##1 rstPinS && !latch_ff && !keyReset ##1 !rstPinS && !keyReset;
   endsequence

   sequence tickRelease;
      latch_ff && tickHi && !rstPinS && !keyReset;
   endsequence

   latch_set_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      pinValid |=> latch_ff ##1 (latch_ff || !rstPinS))
      else $error("latch not set by a valid reset pin");

   latch_hold_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      latch_ff && !tickHi |=> latch_ff)
      else $error("latch released without the 2 Hz tick");

   noise_reject_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      shortPulse |=> !latch_ff)
      else $error("single sample reset pulse started a reset");

   tick_release_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      tickRelease |=> !initReset && cpuRun)
      else $error("reset not released on tick with pin low");

   tick_phase_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      oscEdge && (divCnt_ff == DIV_HALF - DIV_W'(1)) |=> tickHi ##1 $stable(tickHi) || oscEdge)
      else $error("2 Hz tick did not rise at half period");

   key_or_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      keyReset |=> initReset)
      else $error("qualified key combination did not reset");

   halver_block_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      hsClkActive |=> !supply.coreHalver && !supply.lcdHalver)
      else $error("halver set while fast clock active");

   reset_normal_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      latch_ff |=> !supply.coreHalver && !supply.lcdHalver && !supply.hsRegEnable)
      else $error("supply not normal during initial reset");

   lcd_level_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      wrLevel && !latch_ff |=> supply.lcdBaseLevel == $past(wdata[3:0]))
      else $error("lcd base level not taken from write");

   status_read_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      rdStb && selStatus |=> rdata[`RSP_BIT_ST_LATCH] == $past(latch_ff) ##1 rdata == '0
      || $past(rdStb))
      else $error("status read does not show the reset latch");

   // two high samples after a low one are a real reset request
   sequence pinHeld;
      !rstPinS ##1 rstPinS [*2];
   endsequence

   pin_latency_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      pinHeld |=> latch_ff)
      else $error("held reset pin did not set the latch");

   div_wrap_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      oscEdge && (divCnt_ff == DIV_LAST) |=> (divCnt_ff == '0) && !tickHi)
      else $error("2 Hz divider did not wrap to the low half");

   hs_enable_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      wrSupply && !latch_ff |=> supply.hsRegEnable == $past(wdata[`RSP_BIT_HS_REG_EN]))
      else $error("high-speed regulator enable not taken from write");

   core_source_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      wrSupply && !latch_ff
      |=> supply.coreFromHighSpeed == $past(wdata[`RSP_BIT_CORE_FROM_HS]))
      else $error("core voltage source not taken from write");

   halver_write_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      wrSupply && !latch_ff && !hsClkActive
      |=> supply.coreHalver == $past(wdata[`RSP_BIT_CORE_HALVER])
          && supply.lcdHalver == $past(wdata[`RSP_BIT_LCD_HALVER]))
      else $error("halver bits not taken from write");

   lcd_switch_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      wrSupply && !latch_ff |=> supply.lcdSupplyOn == $past(wdata[`RSP_BIT_LCD_ON]))
      else $error("lcd supply switch not taken from write");

   supply_hold_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      !wrSupply && !wrLevel && !latch_ff && !hsClkActive |=> $stable(supply))
      else $error("supply controls changed without a write");

endmodule : rsp_init_reset

`default_nettype wire

/* src/rsp_map.svh */
`ifndef RSP_MAP_SVH
`define RSP_MAP_SVH

// register offsets on the plain register port
`define RSP_ADDR_W           4
`define RSP_DATA_W           8
`define RSP_OFS_SUPPLY       4'h0
`define RSP_OFS_LCD_LEVEL    4'h1
`define RSP_OFS_STATUS       4'h2

// supply control field positions
`define RSP_BIT_HS_REG_EN    0
`define RSP_BIT_CORE_FROM_HS 1
`define RSP_BIT_CORE_HALVER  2
`define RSP_BIT_LCD_HALVER   3
`define RSP_BIT_LCD_ON       4

// status field positions
`define RSP_BIT_ST_LATCH     0
`define RSP_BIT_ST_KEY_RST   1
`define RSP_BIT_ST_KEY_FILT  2
`define RSP_BIT_ST_HS_CLK    3
`define RSP_BIT_ST_TICK      4

// reset values
`define RSP_RST_SUPPLY       8'h00
`define RSP_RST_LCD_LEVEL    4'h0

// timing: reference clock, pin noise, oscillator based times
`define RSP_CLK_NS           100
`define RSP_RST_NOISE_NS     100
`define RSP_RST_NOISE_SMP    ((`RSP_RST_NOISE_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS + 1)
`define RSP_OSC_HZ           32768
`define RSP_TICK_HZ          2
`define RSP_OSC_DIV          (`RSP_OSC_HZ / `RSP_TICK_HZ)
`define RSP_KEY_FILT_US      1500
`define RSP_KEY_FILT_EDGES   ((`RSP_KEY_FILT_US * `RSP_OSC_HZ) / 1000000)
`define RSP_KEY_HOLD_MS      1000
`define RSP_KEY_HOLD_EDGES   ((`RSP_KEY_HOLD_MS * `RSP_OSC_HZ) / 1000)

`endif

/* src/rsp_pkg.sv */
package rsp_pkg;

   // build-time choice of key combination
   typedef enum logic [1:0] {
      RSP_KEY_OFF,
      RSP_KEY_01,
      RSP_KEY_012,
      RSP_KEY_0123
   } rsp_key_opt_t;

   // supply controls seen by the analog side
   typedef struct packed {
      logic       hsRegEnable;       // high-speed regulator on
      logic       coreFromHighSpeed; // core voltage from high-speed regulator
      logic       coreHalver;        // low-speed regulator halved
      logic       lcdHalver;         // lcd supply halved
      logic       lcdSupplyOn;       // lcd supply circuit on
      logic [3:0] lcdBaseLevel;      // lcd base level step
   } rsp_supply_t;

endpackage : rsp_pkg

/* src/rsp_sync.sv */
`timescale 1ns/100ps
`default_nettype none

// two flip-flop synchroniser for pin levels
module rsp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   // asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;  // first stage, read only by second stage
   logic [W-1:0] sync_ff;  // second stage

   // plain double flop, nothing taps the first stage
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;

endmodule : rsp_sync

`default_nettype wire

/* src/rsp_key_qual.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rsp_map.svh"

// key combination: noise reject then hold qualification
module rsp_key_qual #(
   parameter rsp_pkg::rsp_key_opt_t KEY_OPT   = rsp_pkg::RSP_KEY_0123,
   parameter bit                    QUALIFY   = 1'b1,
   parameter int                    FILT_EDGE = `RSP_KEY_FILT_EDGES,
   parameter int                    HOLD_EDGE = `RSP_KEY_HOLD_EDGES
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // synchronised keys and oscillator edge
   input  wire logic [3:0] keySync,
   input  wire logic       oscEdge,
   // results
   output logic            keyFiltered,
   output logic            keyReset
);

   typedef enum logic [1:0] {KQ_IDLE, KQ_FILTER, KQ_HOLD, KQ_FIRE} rsp_kq_state_t;

   // selected keys for an option
   function automatic logic [3:0] keyMask(rsp_pkg::rsp_key_opt_t opt);
      case (opt)
         rsp_pkg::RSP_KEY_01:   keyMask = 4'h3;
         rsp_pkg::RSP_KEY_012:  keyMask = 4'h7;
         rsp_pkg::RSP_KEY_0123: keyMask = 4'hF;
         default:               keyMask = 4'h0;
      endcase
   endfunction : keyMask

   localparam logic [3:0]  MASK      = keyMask(KEY_OPT);
   localparam logic [15:0] FILT_LAST = 16'(FILT_EDGE - 1);
   localparam logic [15:0] HOLD_LAST = 16'(HOLD_EDGE - 1);

   rsp_kq_state_t state_ff;   // qualifier state
   rsp_kq_state_t nxt_state;
   logic [15:0]   cnt_ff;     // oscillator edges in this state
   logic [15:0]   nxt_cnt;

   // extra keys held high do not spoil the match
   wire keyAll  = (MASK != 4'h0) && ((keySync & MASK) == MASK);
   wire cntDone = (state_ff == KQ_FILTER) ? (cnt_ff == FILT_LAST) : (cnt_ff == HOLD_LAST);

   // next state: any drop of the combination starts over
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      if (!keyAll) begin
         nxt_state = KQ_IDLE;
         nxt_cnt   = 16'h0000;
      end else begin
         case (state_ff)
            KQ_IDLE: begin
               nxt_state = KQ_FILTER;
               nxt_cnt   = 16'h0000;
            end
            KQ_FILTER, KQ_HOLD: begin
               // counting runs only on oscillator edges
               if (oscEdge && cntDone) begin
                  nxt_cnt   = 16'h0000;
                  if (state_ff == KQ_FILTER && QUALIFY) begin
                     nxt_state = KQ_HOLD;
                  end else begin
                     nxt_state = KQ_FIRE;
                  end
               end else if (oscEdge) begin
                  nxt_cnt = cnt_ff + 16'h0001;
               end
            end
            KQ_FIRE: nxt_state = KQ_FIRE;
            default: nxt_state = KQ_IDLE;
         endcase
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= KQ_IDLE;
         cnt_ff   <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   assign keyFiltered = (state_ff == KQ_HOLD) || (state_ff == KQ_FIRE);
   assign keyReset    = (state_ff == KQ_FIRE);

endmodule : rsp_key_qual

`default_nettype wire

/* dv/rsp_ext_model.sv */
`timescale 1ns/100ps
`default_nettype none

// reset switch, key switches and low-speed crystal outside the chip
module rsp_ext_model (
   // reference timing
   input  wire logic ref_clk,
   // pins into the block
   output logic       resetPin,
   output logic       lowSpeedOsc,
   output logic [3:0] keyIn
);
   localparam int OSC_HALF_NS  = 400;  // shortened crystal half period
   localparam int OSC_START_NS = 2000; // crystal start-up delay

   // pins idle low, as the pull-downs leave them
   initial begin
      resetPin    = 1'b0;
      keyIn       = 4'h0;
      lowSpeedOsc = 1'b0;
      #(OSC_START_NS); // crystal silent until it starts
      forever #(OSC_HALF_NS) lowSpeedOsc = ~lowSpeedOsc;
   end

   // hold the reset pin high for a number of reference cycles
   task automatic pin_pulse(input int cyc);
      @(posedge ref_clk) resetPin <= 1'b1;
      repeat (cyc) @(posedge ref_clk);
      resetPin <= 1'b0;
   endtask : pin_pulse

   // press keys for a number of crystal edges, only once it runs
   task automatic key_press(input logic [3:0] k, input int edges);
      wait (lowSpeedOsc);
      @(posedge ref_clk) keyIn <= k;
      repeat (edges) @(posedge lowSpeedOsc);
      @(posedge ref_clk) keyIn <= 4'h0;
   endtask : key_press
endmodule : rsp_ext_model

`default_nettype wire

/* dv/initial_reset_and_supply_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rsp_map.svh"

// self-checking bench for reset latch, key reset and supply controls
module initial_reset_and_supply_control_tb_top;
   logic                 ref_clk;     // 10 MHz
   logic                 rst_b;       // async reset
   logic                 hsClkActive; // fast clock in use
   logic                 wrStb;       // write strobe
   logic                 rdStb;       // read strobe
   logic [3:0]           addr;        // register address
   logic [7:0]           wdata;       // write data
   logic [7:0]           rdata;       // read data
   logic                 initReset;   // internal reset
   logic                 cpuRun;      // cpu may run
   logic                 resetPin;    // from partner
   logic                 lowSpeedOsc; // from partner
   logic [3:0]           keyIn;       // from partner
   rsp_pkg::rsp_supply_t supply;      // supply controls
   int                   n_errors;    // mismatches
   int                   checked;     // comparisons
   int                   mSup;        // model of supply bits
   int                   mLvl;        // model of lcd level
   logic [31:0]          rng;         // xorshift state

   // clock
   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   // short divider and filter counts keep the run brief
   rsp_init_reset #(
      .KEY_OPT  (rsp_pkg::RSP_KEY_012),
      .OSC_DIV  (8),
      .FILT_EDGE(2),
      .HOLD_EDGE(4)
   ) DUT (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .resetPin   (resetPin),
      .lowSpeedOsc(lowSpeedOsc),
      .keyIn      (keyIn),
      .hsClkActive(hsClkActive),
      .addr       (addr),
      .wdata      (wdata),
      .wrStb      (wrStb),
      .rdStb      (rdStb),
      .rdata      (rdata),
      .initReset  (initReset),
      .cpuRun     (cpuRun),
      .supply     (supply)
   );

   // far side
   rsp_ext_model EXT (
      .ref_clk    (ref_clk),
      .resetPin   (resetPin),
      .lowSpeedOsc(lowSpeedOsc),
      .keyIn      (keyIn)
   );

   // random source
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   // expected supply word, struct order
   function automatic logic [8:0] exp_sup();
      return {mSup[0], mSup[1], mSup[2], mSup[3], mSup[4], mLvl[3:0]};
   endfunction : exp_sup

   // single flag compare
   task automatic chk_flag(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_flag

   // data word compare
   task automatic chk_data(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_data

   // one-cycle write, then supply compared with the model
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wrStb <= 1'b1;
      @(posedge ref_clk);
      wrStb <= 1'b0;
      // halver bits refused under the fast clock
      if (a == `RSP_OFS_SUPPLY) mSup = d[4:0] & (hsClkActive ? 5'h13 : 5'h1F);
      if (a == `RSP_OFS_LCD_LEVEL) mLvl = d[3:0];
      @(negedge ref_clk);
      chk_data(supply, exp_sup());
   endtask : reg_wr

   // one-cycle read, data looked at in the following cycle only
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge ref_clk);
      addr  <= a;
      rdStb <= 1'b1;
      @(posedge ref_clk);
      rdStb <= 1'b0;
      @(negedge ref_clk);
      chk_data({1'b0, rdata & m}, {1'b0, e});
   endtask : reg_rd

   // bounded wait for the cpu to be let go
   task automatic wait_run(input int bound);
      int n;
      n = 0;
      while (cpuRun !== 1'b1 && n < bound) begin
         @(negedge ref_clk);
         n++;
      end
      chk_flag(cpuRun, 1'b1);
      chk_flag(initReset, 1'b0);
   endtask : wait_run

   // verdict
   task automatic complete_run();
      $display("counts: checked=%0d errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   // watchdog, well past the expected few thousand cycles
   initial begin
      #(20000 * 100);
      n_errors++;
      complete_run();
   end

   // main sequence
   initial begin
      rst_b = 1'b0;
      hsClkActive = 1'b0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      n_errors = 0;
      checked = 0;
      mSup = 0;
      mLvl = 0;
      rng = 32'h0000_0033;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(negedge ref_clk);
      chk_flag(initReset, 1'b1);
      chk_data(supply, 9'h000);
      wait_run(100);
      EXT.pin_pulse(1000);
      chk_flag(initReset, 1'b1);
      wait_run(120);
      $display("test power-up done");
      // every lcd level
      for (int i = 0; i < 16; i++) begin
         reg_wr(`RSP_OFS_LCD_LEVEL, 8'(i));
         reg_rd(`RSP_OFS_LCD_LEVEL, 8'(i), 8'h0F);
      end
      // random supply words, then each halver alone
      repeat (12) begin
         rng = xs(rng);
         reg_wr(`RSP_OFS_SUPPLY, rng[7:0]);
         reg_rd(`RSP_OFS_SUPPLY, 8'(mSup[4:0]), 8'h1F);
      end
      reg_wr(`RSP_OFS_SUPPLY, 8'h04);
      reg_wr(`RSP_OFS_SUPPLY, 8'h08);
      reg_wr(`RSP_OFS_SUPPLY, 8'h00);
      // fast clock: halvers cannot be set
      @(posedge ref_clk) hsClkActive <= 1'b1;
      reg_wr(`RSP_OFS_SUPPLY, 8'h1F);
      reg_rd(`RSP_OFS_STATUS, 8'h08, 8'h0F);
      reg_wr(`RSP_OFS_SUPPLY, 8'h00);
      @(posedge ref_clk) hsClkActive <= 1'b0;
      reg_wr(`RSP_OFS_SUPPLY, 8'h1C);
      // unmapped place
      reg_wr(4'hF, 8'hFF);
      reg_rd(4'hF, 8'h00, 8'hFF);
      $display("test registers done");
      // one-sample glitch is ignored
      EXT.pin_pulse(1);
      repeat (10) begin
         @(negedge ref_clk);
         chk_flag(initReset, 1'b0);
      end
      // full pulse resets and clears supply
      fork
         EXT.pin_pulse(1000);
         begin
            repeat (6) @(negedge ref_clk);
            chk_flag(initReset, 1'b1);
            chk_data(supply, 9'h000);
         end
      join
      mSup = 0;
      mLvl = 0;
      chk_flag(cpuRun, 1'b0);
      wait_run(120);
      $display("test reset pin done");
      // short press and missing key do nothing
      EXT.key_press(4'h7, 3);
      EXT.key_press(4'hB, 20);
      @(negedge ref_clk);
      chk_flag(initReset, 1'b0);
      // long press with an extra key resets
      reg_wr(`RSP_OFS_SUPPLY, 8'h11);
      fork
         EXT.key_press(4'hF, 20);
         begin
            repeat (3) @(posedge lowSpeedOsc);
            @(negedge ref_clk);
            chk_flag(initReset, 1'b0);
         end
      join
      @(negedge ref_clk);
      chk_flag(initReset, 1'b1);
      chk_data(supply, 9'h000);
      mSup = 0;
      mLvl = 0;
      wait_run(150);
      $display("test key reset done");
      complete_run();
   end
endmodule : initial_reset_and_supply_control_tb_top

`default_nettype wire
